/* rtl/vram_grant_ctrl.sv */
/*
 * controller end: port arbitration, lock, refresh slots, row/column
 * strobes and the transfer/output-enable strobe for video loads.
 * assumes the bus end muxes its port signals by the grant output and
 * drives everything synchronously to i_clock.
 */
////////////////////////////////////////////////////////////////////////
// Functional notes
// - grant high gives second port the array
// - grant low gives first port the array
// - bus end muxes port signals by grant
// - lock by owner stalls the other port
// - early request precedes load strobe enough
// - early request blocks port two, refresh
// - early request held or pulsed both accepted
// - load strobe fall drops output enable immediately
// - load strobe falls before row strobe
// - enable rises on strobe rise or edge four
// - write indicator ignored during load access
// - reads: enable follows column strobes if optioned
// - port two request latches, starts row strobe
// - early ack rises with port two row strobe
module vram_grant_ctrl import vram_grant_pkg::*; (
	input wire logic i_clock,
	input wire logic i_resetn,
	vram_port_if.device bus,
	input wire logic i_refresh_request,
	input wire logic i_oe_follows_cas,
	input wire logic i_latch_addresses,
	output logic o_row_strobe_n,
	output logic [ECAS_W-1:0] o_column_strobe_n,
	output logic o_transfer_output_enable_n,
	output logic [ROW_W-1:0] o_memory_address,
	output logic [BANK_W-1:0] o_bank_select,
	output logic o_refresh_active
);

	typedef struct packed {
		arb_state_t state;
		logic grant;
		logic [3:0] cnt;
		logic [2:0] xfer_cnt;
		logic hold;
		logic [2:0] hold_cnt;
		logic load_access;
		logic [COL_W-1:0] col;
		logic ras_n;
		logic [ECAS_W-1:0] cas_n;
		logic oe_n;
		logic ack_a;
		logic ack_b;
		logic [ROW_W-1:0] mem_addr;
		logic [BANK_W-1:0] bank;
		logic refresh_active;
	} ctrl_state_t;

	localparam ctrl_state_t RESET_STATE = '{
		state: ST_IDLE,
		grant: 1'b0,
		cnt: 4'h0,
		xfer_cnt: 3'h0,
		hold: 1'b0,
		hold_cnt: 3'h0,
		load_access: 1'b0,
		col: '0,
		ras_n: 1'b1,
		cas_n: '1,
		oe_n: 1'b1,
		ack_a: 1'b0,
		ack_b: 1'b0,
		mem_addr: '0,
		bank: '0,
		refresh_active: 1'b0
	};

	ctrl_state_t cur;
	ctrl_state_t next;
	logic strobe_low;
	logic blocked;
	logic req_owner;
	logic [COL_W-1:0] col_now;

	// inputs arrive on the same clock, so no synchronisers
	assign strobe_low = ~bus.shift_load_strobe_n;
	assign blocked = ~bus.early_transfer_request_n | cur.hold;
	assign req_owner = cur.grant ? bus.second_port_request
		: bus.first_port_request;
	assign col_now = i_latch_addresses ? cur.col
		: bus.column_address_inputs;

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next = cur;

		// edges seen since the load strobe fell; restarts when it rises
		if (!strobe_low)
			next.xfer_cnt = 3'h0;
		else if (cur.xfer_cnt != XFER_DONE)
			next.xfer_cnt = cur.xfer_cnt + 3'h1;

		// hold outlives a short early request until four periods pass
		if (cur.hold)
		begin
			if (strobe_low || cur.hold_cnt != 3'h0)
			begin
				if (cur.hold_cnt == XFER_LAST)
				begin
					next.hold = 1'b0;
					next.hold_cnt = 3'h0;
				end
				else
					next.hold_cnt = cur.hold_cnt + 3'h1;
			end
		end
		else if (!bus.early_transfer_request_n)
			next.hold = 1'b1;

		// load access lasts until its row strobe has ended
		if (strobe_low)
			next.load_access = 1'b1;
		else if (cur.state != ST_ACCESS)
			next.load_access = 1'b0;

		case (cur.state)
		ST_IDLE:
		begin
			next.ras_n = 1'b1;
			next.cas_n = '1;
			next.ack_a = 1'b0;
			next.ack_b = 1'b0;
			// grant flips only here, with no row strobe active
			if (i_refresh_request && !blocked)
			begin
				next.state = ST_REFRESH;
				next.ras_n = 1'b0;
				next.cnt = 4'h0;
				next.refresh_active = 1'b1;
			end
			else if (!cur.grant)
			begin
				if (bus.first_port_request)
				begin
					next.state = ST_ACCESS;
					next.ras_n = 1'b0;
					next.ack_a = 1'b1;
				end
				else if (bus.second_port_request && !bus.lock && !blocked)
					next.grant = 1'b1;
			end
			else
			begin
				if (bus.second_port_request && !blocked)
				begin
					next.state = ST_ACCESS;
					next.ras_n = 1'b0;
					next.ack_b = 1'b1;
				end
				else if (bus.first_port_request && !bus.lock)
					next.grant = 1'b0;
			end
			if (next.state == ST_ACCESS)
			begin
				next.mem_addr = bus.row_address_inputs;
				next.col = bus.column_address_inputs;
				next.bank = bus.bank_select_inputs;
			end
		end
		ST_ACCESS:
		begin
			if (!req_owner)
			begin
				next.state = ST_PRECHARGE;
				next.ras_n = 1'b1;
				next.cas_n = '1;
				next.ack_a = 1'b0;
				next.ack_b = 1'b0;
				next.cnt = 4'h0;
			end
			else
			begin
				next.cas_n = ~bus.column_strobe_enables;
				next.mem_addr = col_now;
			end
		end
		ST_REFRESH:
		begin
			if (cur.cnt == REFRESH_LAST)
			begin
				next.state = ST_PRECHARGE;
				next.ras_n = 1'b1;
				next.cnt = 4'h0;
				next.refresh_active = 1'b0;
			end
			else
				next.cnt = cur.cnt + 4'h1;
		end
		ST_PRECHARGE:
		begin
			if (cur.cnt == PRECHARGE_LAST)
				next.state = ST_IDLE;
			else
				next.cnt = cur.cnt + 4'h1;
		end
		default:
			next = RESET_STATE;
		endcase

		// read path: enable tracks column strobes when optioned
		if (i_oe_follows_cas && !bus.write_indicator)
			next.oe_n = &next.cas_n;
		else
			next.oe_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			cur <= RESET_STATE;
		else
			cur <= next;
	end

	////////////////////////////////////////////////////////////////////
	// the enable must fall with the strobe itself, so it is gated here
	// rather than waiting for the next edge; write state is masked out
	always_comb
	begin
		if (strobe_low || cur.load_access)
			o_transfer_output_enable_n =
				!strobe_low || cur.xfer_cnt == XFER_DONE;
		else
			o_transfer_output_enable_n = cur.oe_n;
	end

	assign bus.second_port_granted = cur.grant;
	assign bus.second_port_early_ack = cur.ack_b;
	assign bus.first_port_ack = cur.ack_a;
	assign o_row_strobe_n = cur.ras_n;
	assign o_column_strobe_n = cur.cas_n;
	assign o_memory_address = cur.mem_addr;
	assign o_bank_select = cur.bank;
	assign o_refresh_active = cur.refresh_active;

endmodule

/* rtl/vram_grant_pkg.sv */
/*
 * shared constants, state encodings and widths for the dual-port grant
 * and video transfer logic of the video ram controller.
 * assumes one 25 MHz system clock for every party.
 */
package vram_grant_pkg;

	localparam int ROW_W = 9;
	localparam int COL_W = 9;
	localparam int BANK_W = 2;
	localparam int ECAS_W = 2;

	localparam int SYS_CLOCK_MHZ = 25;
	localparam int PRECHARGE_NS = 80;
	localparam int REFRESH_LOW_NS = 120;
	localparam int PRECHARGE_CLOCKS =
		(PRECHARGE_NS * SYS_CLOCK_MHZ + 999) / 1000;
	localparam int REFRESH_CLOCKS =
		(REFRESH_LOW_NS * SYS_CLOCK_MHZ + 999) / 1000;
	localparam logic [3:0] PRECHARGE_LAST = 4'(PRECHARGE_CLOCKS - 1);
	localparam logic [3:0] REFRESH_LAST = 4'(REFRESH_CLOCKS - 1);

	// transfer strobe window, in system clock periods
	localparam int XFER_PERIODS = 4;
	localparam logic [2:0] XFER_DONE = 3'(XFER_PERIODS);
	localparam logic [2:0] XFER_LAST = 3'(XFER_PERIODS - 1);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ACCESS = 4'h2,
		ST_REFRESH = 4'h4,
		ST_PRECHARGE = 4'h8
	} arb_state_t;

	typedef enum logic [2:0] {
		LD_IDLE = 3'h1,
		LD_LEAD = 3'h2,
		LD_STROBE = 3'h4
	} load_state_t;

endpackage

/* rtl/vram_port_if.sv */
/*
 * pins between the controller end and the bus/video end.
 * all signals are synchronous to the shared system clock.
 */
interface vram_port_if;
	import vram_grant_pkg::*;

	logic first_port_request;
	logic second_port_request;
	logic lock;
	logic write_indicator;
	logic [ECAS_W-1:0] column_strobe_enables;
	logic [ROW_W-1:0] row_address_inputs;
	logic [COL_W-1:0] column_address_inputs;
	logic [BANK_W-1:0] bank_select_inputs;
	logic early_transfer_request_n;
	logic shift_load_strobe_n;
	logic second_port_granted;
	logic second_port_early_ack;
	logic first_port_ack;

	modport device (
		input first_port_request, second_port_request, lock,
		input write_indicator, column_strobe_enables,
		input row_address_inputs, column_address_inputs,
		input bank_select_inputs, early_transfer_request_n,
		input shift_load_strobe_n,
		output second_port_granted, second_port_early_ack, first_port_ack
	);

	modport host (
		output first_port_request, second_port_request, lock,
		output write_indicator, column_strobe_enables,
		output row_address_inputs, column_address_inputs,
		output bank_select_inputs, early_transfer_request_n,
		output shift_load_strobe_n,
		input second_port_granted, second_port_early_ack, first_port_ack
	);

endinterface

/* rtl/vram_bus_end.sv */
/*
 * bus/video end: muxes the two cpu ports onto the controller by the
 * grant, and sequences early request, load strobe and load access.
 * assumes the controller end shares i_clock.
 */
module vram_bus_end import vram_grant_pkg::*; #(
	parameter logic [7:0] LEAD_CLOCKS = 8'h08,
	parameter logic [7:0] STROBE_CLOCKS = 8'h06
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	vram_port_if.host bus,
	input wire logic i_a_request,
	input wire logic i_a_lock,
	input wire logic i_a_write,
	input wire logic [ROW_W-1:0] i_a_row,
	input wire logic [COL_W-1:0] i_a_col,
	input wire logic [BANK_W-1:0] i_a_bank,
	input wire logic [ECAS_W-1:0] i_a_ecas,
	input wire logic i_b_request,
	input wire logic i_b_lock,
	input wire logic i_b_write,
	input wire logic [ROW_W-1:0] i_b_row,
	input wire logic [COL_W-1:0] i_b_col,
	input wire logic [BANK_W-1:0] i_b_bank,
	input wire logic [ECAS_W-1:0] i_b_ecas,
	input wire logic i_load_start,
	input wire logic i_load_pulsed,
	output logic o_a_ack,
	output logic o_b_ack,
	output logic o_load_busy
);

	typedef struct packed {
		load_state_t state;
		logic [7:0] cnt;
		logic early_n;
		logic strobe_n;
		logic load_req;
		logic a_ack;
		logic b_ack;
		logic busy;
	} bus_state_t;

	localparam bus_state_t RESET_STATE = '{
		state: LD_IDLE,
		cnt: 8'h00,
		early_n: 1'b1,
		strobe_n: 1'b1,
		load_req: 1'b0,
		a_ack: 1'b0,
		b_ack: 1'b0,
		busy: 1'b0
	};

	bus_state_t cur;
	bus_state_t next;
	logic gb;

	assign gb = bus.second_port_granted;

	////////////////////////////////////////////////////////////////////
	// the mux is combinational so a grant change reaches the controller
	// before its next edge
	assign bus.row_address_inputs = gb ? i_b_row : i_a_row;
	assign bus.column_address_inputs = gb ? i_b_col : i_a_col;
	assign bus.bank_select_inputs = gb ? i_b_bank : i_a_bank;
	assign bus.write_indicator = gb ? i_b_write : i_a_write;
	assign bus.lock = gb ? i_b_lock : i_a_lock;
	assign bus.column_strobe_enables = gb ? i_b_ecas : i_a_ecas;
	assign bus.first_port_request = i_a_request | cur.load_req;
	assign bus.second_port_request = i_b_request;
	assign bus.early_transfer_request_n = cur.early_n;
	assign bus.shift_load_strobe_n = cur.strobe_n;

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next = cur;
		next.a_ack = bus.first_port_ack;
		next.b_ack = bus.second_port_early_ack;
		case (cur.state)
		LD_IDLE:
		begin
			if (i_load_start)
			begin
				next.state = LD_LEAD;
				next.early_n = 1'b0;
				next.cnt = 8'h00;
				next.busy = 1'b1;
			end
		end
		LD_LEAD:
		begin
			if (i_load_pulsed)
				next.early_n = 1'b1;
			if (cur.cnt == LEAD_CLOCKS - 8'h01)
			begin
				// strobe falls and request rises together: row strobe follows
				next.state = LD_STROBE;
				next.strobe_n = 1'b0;
				next.load_req = 1'b1;
				next.cnt = 8'h00;
			end
			else
				next.cnt = cur.cnt + 8'h01;
		end
		LD_STROBE:
		begin
			if (cur.cnt == STROBE_CLOCKS - 8'h01)
			begin
				next.state = LD_IDLE;
				next.strobe_n = 1'b1;
				next.load_req = 1'b0;
				next.early_n = 1'b1;
				next.busy = 1'b0;
			end
			else
				next.cnt = cur.cnt + 8'h01;
		end
		default:
			next = RESET_STATE;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			cur <= RESET_STATE;
		else
			cur <= next;
	end

	assign o_a_ack = cur.a_ack;
	assign o_b_ack = cur.b_ack;
	assign o_load_busy = cur.busy;

endmodule

/* verif/vram_port_asserts.sv */
/*
 * checker for the grant and transfer pins between the two ends.
 * assumes every signal is sampled on i_clock, reset sync low.
 */
module vram_port_asserts (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic lock,
	input wire logic early_transfer_request_n,
	input wire logic shift_load_strobe_n,
	input wire logic second_port_granted,
	input wire logic second_port_early_ack,
	input wire logic first_port_ack,
	input wire logic o_row_strobe_n,
	input wire logic o_transfer_output_enable_n
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////////////////////////////////
	b_owner_a: assert property (second_port_early_ack |->
		second_port_granted) else $error("b acked without grant");
	a_owner_a: assert property (first_port_ack |->
		!second_port_granted) else $error("a acked while b granted");
	lock_hold_a: assert property (lock |=>
		$stable(second_port_granted)) else $error("grant moved in lock");
	early_block_a: assert property (!early_transfer_request_n |=>
		!$rose(second_port_early_ack)) else $error("b ran past request");
	hold_block_a: assert property ($fell(shift_load_strobe_n) |->
		(!$rose(second_port_early_ack))[*4]) else $error("b ran in hold");
	// oe must already be low at the first edge, so fall is not clocked
	oe_fall_a: assert property ($fell(shift_load_strobe_n) |->
		!o_transfer_output_enable_n) else $error("oe late on load");
	oe_window_a: assert property ($fell(shift_load_strobe_n) |->
		(!o_transfer_output_enable_n)[*3] ##[1:2] o_transfer_output_enable_n)
		else $error("oe window wrong");
	b_ack_ras_a: assert property (second_port_early_ack |->
		!o_row_strobe_n) else $error("b ack without row strobe");
	grant_idle_a: assert property ($changed(second_port_granted) |->
		$past(!first_port_ack && !second_port_early_ack))
		else $error("grant moved in access");
endmodule

/* verif/vram_dual_port_grant_and_transfer_bench.sv */
/*
 * self-checking bench: both ends joined by the port interface.
 * assumes only the two ends, the interface and the checker.
 */
module vram_dual_port_grant_and_transfer_bench import vram_grant_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic rq_ref, oe_opt, latch, a_req, a_lock, a_wr, b_req, b_lock, b_wr;
	logic ld_start, ld_pulsed, ras_n, oe_n, ref_act;
	logic [ROW_W-1:0] a_row, b_row, maddr;
	logic [COL_W-1:0] a_col, b_col;
	logic [BANK_W-1:0] a_bank, b_bank;
	logic [ECAS_W-1:0] a_ecas, b_ecas;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	vram_port_if vram_port_if_inst ();
	wire ga = vram_port_if_inst.second_port_granted;
	wire aa = vram_port_if_inst.first_port_ack;
	wire ab = vram_port_if_inst.second_port_early_ack;
	wire sl = vram_port_if_inst.shift_load_strobe_n;
	always #20 i_clock = ~i_clock;
	vram_grant_ctrl vram_grant_ctrl_inst (.i_clock(i_clock),
		.i_resetn(i_resetn), .bus(vram_port_if_inst),
		.i_refresh_request(rq_ref), .i_oe_follows_cas(oe_opt),
		.i_latch_addresses(latch), .o_row_strobe_n(ras_n),
		.o_column_strobe_n(), .o_transfer_output_enable_n(oe_n),
		.o_memory_address(maddr), .o_bank_select(),
		.o_refresh_active(ref_act));
	vram_bus_end vram_bus_end_inst (.i_clock(i_clock), .i_resetn(i_resetn),
		.bus(vram_port_if_inst), .i_a_request(a_req), .i_a_lock(a_lock),
		.i_a_write(a_wr), .i_a_row(a_row), .i_a_col(a_col),
		.i_a_bank(a_bank), .i_a_ecas(a_ecas), .i_b_request(b_req),
		.i_b_lock(b_lock), .i_b_write(b_wr), .i_b_row(b_row),
		.i_b_col(b_col), .i_b_bank(b_bank), .i_b_ecas(b_ecas),
		.i_load_start(ld_start), .i_load_pulsed(ld_pulsed),
		.o_a_ack(), .o_b_ack(), .o_load_busy());
	vram_port_asserts vram_port_asserts_inst (.i_clock(i_clock),
		.i_resetn(i_resetn), .lock(vram_port_if_inst.lock),
		.early_transfer_request_n(vram_port_if_inst.early_transfer_request_n),
		.shift_load_strobe_n(sl), .second_port_granted(ga),
		.second_port_early_ack(ab), .first_port_ack(aa),
		.o_row_strobe_n(ras_n), .o_transfer_output_enable_n(oe_n));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [8:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a hang in arbitration must not stall the run forever
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles > 4000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	function automatic logic [8:0] pick(input logic b, input logic [8:0] x, y);
		return b ? y : x;
	endfunction
	task automatic wait_ack(input logic b);
		for (int i = 0; i < 40 && !(b ? ab : aa); i++)
			tick(1);
	endtask
	task automatic access(input logic b);
		{a_row, b_row, a_col, b_col} = 36'({$urandom, $urandom});
		{a_wr, b_wr, a_bank, b_bank, a_ecas, b_ecas} = 10'($urandom);
		a_req = !b;
		b_req = b;
		wait_ack(b);
		chk("grant", ga, b);
		chk("ras", ras_n, 1'b0);
		chk("row", maddr, pick(b, a_row, b_row));
		tick(1);
		chk("col", maddr, pick(b, a_col, b_col));
		tick($urandom_range(0, 3));
		a_req = 1'b0;
		b_req = 1'b0;
		tick(4);
	endtask
	initial
	begin
		{rq_ref, oe_opt, a_req, a_lock, a_wr, b_req, b_lock, b_wr} = '0;
		{ld_start, ld_pulsed, a_row, b_row, a_col, b_col} = '0;
		{a_bank, b_bank, a_ecas, b_ecas} = '0;
		latch = 1'b1;
		void'($urandom(90536));
		tick(3);
		i_resetn = 1'b1;
		tick(1);
		chk("reset", {ga, aa, ab, oe_n, ras_n}, 5'h03);
		repeat (8)
			access(1'($urandom));
		$display("test random access done");
		b_lock = 1'b1;
		access(1'b1);
		a_req = 1'b1;
		tick(10);
		chk("locked", {ga, aa}, 2'h2);
		b_lock = 1'b0;
		wait_ack(1'b0);
		chk("unlocked", {ga, aa}, 2'h1);
		a_req = 1'b0;
		tick(4);
		$display("test lock done");
		for (int p = 0; p < 2; p++)
		begin
			ld_pulsed = p[0];
			oe_opt = 1'b1;
			a_wr = p[0];
			ld_start = 1'b1;
			tick(1);
			ld_start = 1'b0;
			b_req = 1'b1;
			for (int i = 0; i < 30 && sl; i++)
				@(posedge i_clock) #1;
			chk("oe_fall", oe_n, 1'b0);
			repeat (3) @(posedge i_clock) #1;
			chk("oe_held", {oe_n, ab}, 2'h0);
			@(posedge i_clock) #1;
			chk("oe_rise", {oe_n, ab}, 2'h2);
			@(negedge i_clock);
			wait_ack(1'b1);
			chk("b_after", ab, 1'b1);
			b_req = 1'b0;
			tick(6);
		end
		$display("test video load done");
		rq_ref = 1'b1;
		for (int i = 0; i < 20 && !ref_act; i++)
			tick(1);
		chk("refresh", {ref_act, ras_n, aa, ab}, 4'h8);
		rq_ref = 1'b0;
		tick(8);
		access(1'b0);
		$display("test refresh done");
		tally_and_finish();
	end
endmodule
